// File: rtl/pacc_pkg.sv
// ==========================================================================
// pulse accumulator package
package pacc_pkg;
    // register byte addresses
    localparam logic [7:0] PACC_ADDR_COUNT = 8'h00; // pulse_count_register
    localparam logic [7:0] PACC_ADDR_CTRL = 8'h04; // control bits
    localparam logic [7:0] PACC_ADDR_STAT = 8'h08; // flags, w1c
    localparam logic [7:0] PACC_ADDR_PIN = 8'h0c; // raw pin level, ro
    // control field positions
    localparam int PACC_CTRL_EN = 0; // accumulator enable
    localparam int PACC_CTRL_GATED = 1; // 1 gated time, 0 event count
    localparam int PACC_CTRL_EDGE = 2; // edge_polarity_select
    localparam int PACC_CTRL_EIE = 3; // input_edge_irq_enable
    localparam int PACC_CTRL_OIE = 4; // overflow irq enable
    localparam int PACC_CTRL_W = 5;
    // status field positions
    localparam int PACC_STAT_EDGE = 0; // input_edge_flag
    localparam int PACC_STAT_OVF = 1; // count_overflow_flag
    // reset values
    localparam logic [7:0] PACC_COUNT_RST = 8'h00;
    localparam logic [4:0] PACC_CTRL_RST = 5'h00;
    // timing
    localparam int PACC_TICK_DIV = 64; // bus clocks per gated count
    localparam int PACC_EDGE_GAP = 2; // cycles before next edge may count
    // axi responses
    localparam logic [1:0] PACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PACC_RESP_SLVERR = 2'h2;

    // gathered control bits
    typedef struct packed {
        logic oie;
        logic eie;
        logic edge_sel;
        logic gated;
        logic en;
    } pacc_ctrl_t;

    // one-hot write channel states
    typedef enum logic [2:0] {
        PACC_W_IDLE = 3'b001,
        PACC_W_HAVE = 3'b010,
        PACC_W_RESP = 3'b100
    } pacc_wst_t;
endpackage

// File: rtl/pacc_top.sv
// Functional notes
// - gated trailing edge sets edge flag, interrupt
// - eight-bit counter wraps to zero
// - no gated count while pin is inactive
// - stops at trailing edge, overflow still counts
// - overflow request outranks edge request
// - gated: increment every 64 clocks while active
// - pin level always readable by software
// - polarity bit selects rising or falling edge
// - edge irq needs local and global enable
// - edge flag readable and software clearable
// - pin synchronised, max rate half clock
// - edge recognised then flag set next edge
// - event mode counts with edge flag set
// - no new edge within two cycles
// - free running divide by 64 tick
// - first gated increment phase is uncertain
// - overflow flag set on ff to 00 roll
// - software access never conflicts with increment
// - polarity bit picks inhibiting level when gated
// - separate overflow and edge interrupt requests
// - counting resumes from held value
`timescale 1ns/1ns
module pacc_top
    import pacc_pkg::*;
#(
    parameter int TICK_DIV = PACC_TICK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin and cpu side
    input wire logic accumulator_input_pin,
    input wire logic cpu_irq_mask,
    output logic overflow_irq,
    output logic input_edge_irq
);

    // ======================================================================
    // pin synchroniser and edge detect
    logic pin_s1_q, pin_s2_q, pin_s3_q; // sync chain
    logic [1:0] gap_q, gap_d; // edge lockout counter
    logic pin_active; // gating level
    logic edge_raw; // selected edge seen
    logic edge_hit; // accepted edge
    pacc_ctrl_t ctrl_q, ctrl_d; // control bits, read by edge detect, counter, irq and read sections

    // two flops then history; only s2/s3 feed logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= accumulator_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // polarity choice: high edge_sel = rising edges in event mode, high level active (falling trailing edge) when gated
    // in gated mode a rising select means low inhibits
    always_comb begin
        pin_active = ctrl_q.edge_sel ? pin_s2_q : ~pin_s2_q;
        if (ctrl_q.gated) begin
            // trailing edge of the active level ends the pulse
            edge_raw = ctrl_q.edge_sel ? (pin_s3_q & ~pin_s2_q)
                                       : (~pin_s3_q & pin_s2_q);
        end else begin
            edge_raw = ctrl_q.edge_sel ? (~pin_s3_q & pin_s2_q)
                                       : (pin_s3_q & ~pin_s2_q);
        end
        edge_hit = edge_raw & (gap_q == 2'h0) & ctrl_q.en;
        // lockout so the next edge is at least two cycles later
        if (edge_hit) begin
            gap_d = 2'(PACC_EDGE_GAP - 1);
        end else if (gap_q != 2'h0) begin
            gap_d = gap_q - 2'h1;
        end else begin
            gap_d = gap_q;
        end
    end

    // lockout register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 2'h0;
        end else begin
            gap_q <= gap_d;
        end
    end

    // ======================================================================
    // free running prescaler
    localparam int DW = $clog2(TICK_DIV);
    logic [DW-1:0] div_q, div_d; // never reset by the pin
    logic tick; // one cycle every TICK_DIV clocks

    // tick is independent of the pin, so first count phase varies
    always_comb begin
        tick = (div_q == DW'(TICK_DIV - 1));
        div_d = tick ? '0 : div_q + 1'b1;
    end

    // prescaler register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ======================================================================
    // axi4-lite slave, one write and one read at a time
    pacc_wst_t wst_q, wst_d; // write state
    logic aw_got_q, aw_got_d; // address held
    logic w_got_q, w_got_d; // data held
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d;
    logic wr_fire; // commit of a write this cycle
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic rd_fire;

    // decode helper: is this a mapped register
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == PACC_ADDR_COUNT) || (a == PACC_ADDR_CTRL) ||
                  (a == PACC_ADDR_STAT) || (a == PACC_ADDR_PIN);
    endfunction

    // accept address and data in either order, then answer
    always_comb begin
        wst_d = wst_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bresp_d = bresp_q;
        wr_fire = 1'b0;
        s_axi_awready = 1'b0;
        s_axi_wready = 1'b0;
        case (wst_q)
            PACC_W_IDLE, PACC_W_HAVE: begin
                s_axi_awready = ~aw_got_q;
                s_axi_wready = ~w_got_q;
                if (s_axi_awvalid && !aw_got_q) begin
                    aw_got_d = 1'b1;
                    waddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_got_q) begin
                    w_got_d = 1'b1;
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                end
                wst_d = PACC_W_HAVE;
                if (aw_got_q && w_got_q) begin
                    // both halves held: commit and respond
                    wr_fire = 1'b1;
                    bresp_d = addr_ok(waddr_q) ? PACC_RESP_OKAY
                                               : PACC_RESP_SLVERR;
                    wst_d = PACC_W_RESP;
                end
            end
            PACC_W_RESP: begin
                if (s_axi_bready) begin
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = PACC_W_IDLE;
                end
            end
            default: wst_d = PACC_W_IDLE;
        endcase
    end

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q <= PACC_W_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= PACC_RESP_OKAY;
        end else begin
            wst_q <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
        end
    end

    assign s_axi_bvalid = (wst_q == PACC_W_RESP);
    assign s_axi_bresp = bresp_q;

    // ======================================================================
    // counter, control and flags
    logic [7:0] cnt_q, cnt_d;
    logic roll; // step from all ones this cycle
    logic eflag_q, eflag_d; // input_edge_flag
    logic oflag_q, oflag_d; // count_overflow_flag
    logic eflag_set_q; // edge accepted, flag lands next clock
    logic inc; // counter step this cycle
    logic wr_lane0; // low byte lane written

    // edge recognition cycle, flag set a clock later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eflag_set_q <= 1'b0;
        end else begin
            eflag_set_q <= edge_hit;
        end
    end

    // step source by mode; gated holds value when inactive
    always_comb begin
        wr_lane0 = wr_fire & wstrb_q[0];
        if (!ctrl_q.en) begin
            inc = 1'b0;
        end else if (ctrl_q.gated) begin
            inc = tick & pin_active;
        end else begin
            inc = eflag_set_q;
        end
        cnt_d = cnt_q;
        ctrl_d = ctrl_q;
        eflag_d = eflag_q;
        oflag_d = oflag_q;
        roll = 1'b0;
        // software write applied, then a same-cycle step on top
        if (wr_lane0 && waddr_q == PACC_ADDR_COUNT) begin
            cnt_d = wdata_q[7:0];
        end
        // roll judged on the value really stepped, so a preload written
        // in the same cycle cannot fake or hide an overflow
        if (inc) begin
            roll = (cnt_d == 8'hff);
            cnt_d = cnt_d + 8'h01;
        end
        if (wr_lane0 && waddr_q == PACC_ADDR_CTRL) begin
            ctrl_d = pacc_ctrl_t'(wdata_q[PACC_CTRL_W-1:0]);
        end
        // write one to clear; a same-cycle set wins
        if (wr_lane0 && waddr_q == PACC_ADDR_STAT) begin
            if (wdata_q[PACC_STAT_EDGE]) eflag_d = 1'b0;
            if (wdata_q[PACC_STAT_OVF]) oflag_d = 1'b0;
        end
        if (eflag_set_q) begin
            eflag_d = 1'b1;
        end
        if (roll) begin
            oflag_d = 1'b1;
        end
    end

    // counter and flag registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= PACC_COUNT_RST;
            ctrl_q <= pacc_ctrl_t'(PACC_CTRL_RST);
            eflag_q <= 1'b0;
            oflag_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ctrl_q <= ctrl_d;
            eflag_q <= eflag_d;
            oflag_q <= oflag_d;
        end
    end

    // ======================================================================
    // interrupt requests
    logic ovf_req, edge_req;
    logic ovf_irq_q, edge_irq_q;

    // overflow outranks edge; cpu mask gates both maskable requests
    always_comb begin
        ovf_req = oflag_q & ctrl_q.oie & ~cpu_irq_mask;
        edge_req = eflag_q & ctrl_q.eie & ~cpu_irq_mask
                   & ~ovf_req;
    end

    // registered request outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_irq_q <= 1'b0;
            edge_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_req;
            edge_irq_q <= edge_req;
        end
    end

    assign overflow_irq = ovf_irq_q;
    assign input_edge_irq = edge_irq_q;

    // ======================================================================
    // read channel
    // read data is sampled at address accept so a count step never tears
    always_comb begin
        rd_fire = s_axi_arvalid & ~rvalid_q;
        s_axi_arready = ~rvalid_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_fire) begin
            rvalid_d = 1'b1;
            rresp_d = PACC_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == PACC_ADDR_COUNT) begin
                rdata_d[7:0] = cnt_q;
            end else if (s_axi_araddr == PACC_ADDR_CTRL) begin
                rdata_d[PACC_CTRL_W-1:0] = ctrl_q;
            end else if (s_axi_araddr == PACC_ADDR_STAT) begin
                rdata_d[PACC_STAT_EDGE] = eflag_q;
                rdata_d[PACC_STAT_OVF] = oflag_q;
            end else if (s_axi_araddr == PACC_ADDR_PIN) begin
                rdata_d[0] = pin_s2_q;
            end else begin
                rresp_d = PACC_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // read registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PACC_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // pacc_top

// File: tb/pacc_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// port-level checker for the pulse accumulator
module pacc_assertions
    import pacc_pkg::*;
#(
    parameter int TICK_DIV = PACC_TICK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic accumulator_input_pin,
    input wire logic cpu_irq_mask,
    input wire logic overflow_irq,
    input wire logic input_edge_irq
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // sequences
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ==========================================================
    // interrupt outputs
    a_mask_edge_irq: assert property (
        $past(cpu_irq_mask) |-> !input_edge_irq)
        else $error("edge irq high under global mask");
    a_mask_ovf_irq: assert property (
        $past(cpu_irq_mask) |-> !overflow_irq)
        else $error("overflow irq high under global mask");
    a_irq_priority: assert property (
        overflow_irq |-> !input_edge_irq)
        else $error("edge irq not held off by overflow");

    // ==========================================================
    // register bus
    a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after accept");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after accept");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before rready");
    a_unmapped_slverr: assert property (
        s_ar_taken ##0 (s_axi_araddr > 8'h0c)
        |=> s_axi_rresp == PACC_RESP_SLVERR)
        else $error("unmapped read not refused");
    // pin held steady past the synchroniser must read back as is
    a_pin_readback: assert property (
        s_ar_taken ##0 (s_axi_araddr == PACC_ADDR_PIN && $past(aresetn, 3)
        && $stable(accumulator_input_pin)
        && accumulator_input_pin == $past(accumulator_input_pin, 2)
        && accumulator_input_pin == $past(accumulator_input_pin, 3))
        |=> s_axi_rdata[0] == $past(accumulator_input_pin))
        else $error("pin level read back wrong");
endmodule // pacc_assertions

// File: tb/pacc_pulse_src.sv
`timescale 1ns/1ns
// ==========================================================
// external pulse source on the accumulator pin
module pacc_pulse_src (
    input wire logic aclk,
    output logic accumulator_input_pin
);
    // no pull on this pin, so the source always drives it
    initial begin
        accumulator_input_pin = 1'b0;
    end
    // change just after a rising edge, hold for some cycles
    task automatic drive(input logic lvl, input int cycles);
        @(posedge aclk);
        accumulator_input_pin <= lvl;
        repeat (cycles - 1) @(posedge aclk);
    endtask
    // square wave at half clock: the fastest countable input
    task automatic burst(input int edges);
        repeat (edges) begin
            drive(1'b1, 1);
            drive(1'b0, 1);
        end
    endtask
endmodule // pacc_pulse_src

// File: tb/pacc_top_tb.sv
`timescale 1ns/1ns
module pacc_top_tb;
    import pacc_pkg::*;
    localparam int TDIV = 4; // short tick keeps gated runs brief
    // ==========================================================
    // stimulus and observed signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf; // only lane 0 acts
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic cpu_irq_mask = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, overflow_irq, input_edge_irq;
    logic accumulator_input_pin;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
    logic [31:0] s_axi_rdata, rd_data, g;
    int err_total = 0;
    int samples_checked = 0;

    initial begin
        forever #4 aclk = ~aclk;
    end

    pacc_top #(.TICK_DIV(TDIV)) dut (.*);
    pacc_pulse_src src (.aclk(aclk),
        .accumulator_input_pin(accumulator_input_pin));

    // ==========================================================
    // shared tasks
    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // handshakes judged at the negedge, acted on at the next rise
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_go, w_go, aw_on, w_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (64) begin
            @(negedge aclk);
            aw_go = aw_on && s_axi_awready;
            w_go = w_on && s_axi_wready;
            if (!aw_on && !w_on && s_axi_bvalid === 1'b1) begin
                wr_resp = s_axi_bresp;
                @(posedge aclk);
                s_axi_bready <= 1'b0;
                return;
            end
            @(posedge aclk);
            if (aw_go) begin
                aw_on = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_go) begin
                w_on = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        err_total++; // hung write
        print_verdict();
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [1:0] resp);
        logic ar_on;
        ar_on = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (64) begin
            @(negedge aclk);
            if (!ar_on && s_axi_rvalid === 1'b1) begin
                rd_data = s_axi_rdata;
                resp = s_axi_rresp;
                @(posedge aclk);
                s_axi_rready <= 1'b0;
                return;
            end
            if (s_axi_arready === 1'b1) begin
                ar_on = 1'b0;
                @(posedge aclk);
                s_axi_arvalid <= 1'b0;
            end else begin
                @(posedge aclk);
            end
        end
        err_total++; // hung read
        print_verdict();
    endtask
    task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [1:0] r;
        axi_read(a, r);
        check(rd_data, exp);
    endtask
    // irq outputs as {overflow, edge}, looked at once settled
    task automatic chk_irq(input logic [1:0] exp);
        @(posedge aclk);
        @(negedge aclk);
        check({30'h0, overflow_irq, input_edge_irq}, {30'h0, exp});
        @(posedge aclk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [1:0] r;
        read_chk(PACC_ADDR_COUNT, 32'h0);
        read_chk(PACC_ADDR_CTRL, 32'h0);
        axi_read(8'h10, r);
        check({30'h0, r}, {30'h0, PACC_RESP_SLVERR});
        axi_write(8'h10, 32'h0);
        check({30'h0, wr_resp}, {30'h0, PACC_RESP_SLVERR});
        axi_write(PACC_ADDR_COUNT, 32'ha5);
        check({30'h0, wr_resp}, {30'h0, PACC_RESP_OKAY});
        read_chk(PACC_ADDR_COUNT, 32'ha5);
        src.drive(1'b1, 4);
        read_chk(PACC_ADDR_PIN, 32'h1);
        src.drive(1'b0, 4);
        read_chk(PACC_ADDR_PIN, 32'h0);
    endtask
    // event mode, both polarities, then the fastest input rate
    task automatic t_edge_sel;
        for (int s = 0; s < 2; s++) begin
            axi_write(PACC_ADDR_CTRL, 32'h0);
            src.drive(~s[0], 4);
            axi_write(PACC_ADDR_COUNT, 32'h0);
            axi_write(PACC_ADDR_STAT, 32'h3);
            axi_write(PACC_ADDR_CTRL, {29'h0, s[0], 2'b01});
            src.drive(s[0], 8);
            read_chk(PACC_ADDR_COUNT, 32'h1);
            src.drive(~s[0], 8);
            read_chk(PACC_ADDR_COUNT, 32'h1);
            read_chk(PACC_ADDR_STAT, 32'h1);
        end
        src.burst(10);
        src.drive(1'b0, 4);
        read_chk(PACC_ADDR_COUNT, 32'hb);
    endtask
    task automatic t_ovf_irq;
        axi_write(PACC_ADDR_CTRL, 32'h1d); // rising, both irq enables
        axi_write(PACC_ADDR_COUNT, 32'hfe);
        axi_write(PACC_ADDR_STAT, 32'h3);
        src.burst(3);
        src.drive(1'b0, 4);
        read_chk(PACC_ADDR_COUNT, 32'h1);
        read_chk(PACC_ADDR_STAT, 32'h3);
        chk_irq(2'b10);
        cpu_irq_mask <= 1'b1;
        chk_irq(2'b00);
        cpu_irq_mask <= 1'b0;
        axi_write(PACC_ADDR_STAT, 32'h2);
        chk_irq(2'b01);
        axi_write(PACC_ADDR_STAT, 32'h1);
        chk_irq(2'b00);
        read_chk(PACC_ADDR_STAT, 32'h0);
    endtask
    // gated, high active; first tick may land anywhere in a period
    task automatic t_gated;
        logic [1:0] r;
        axi_write(PACC_ADDR_CTRL, 32'h0);
        axi_write(PACC_ADDR_COUNT, 32'h0);
        axi_write(PACC_ADDR_CTRL, 32'h0f);
        src.drive(1'b0, 20);
        read_chk(PACC_ADDR_COUNT, 32'h0);
        src.drive(1'b1, 10 * TDIV);
        src.drive(1'b0, 8);
        axi_read(PACC_ADDR_COUNT, r);
        g = rd_data;
        check(32'(g >= 9 && g <= 11), 32'h1);
        read_chk(PACC_ADDR_STAT, 32'h1);
        chk_irq(2'b01);
        src.drive(1'b0, 20);
        read_chk(PACC_ADDR_COUNT, g);
        src.drive(1'b1, 10 * TDIV);
        src.drive(1'b0, 8);
        axi_read(PACC_ADDR_COUNT, r);
        check(32'(rd_data - g >= 9 && rd_data - g <= 11), 32'h1);
        // select bit clear: high inhibits, low is the active level
        axi_write(PACC_ADDR_CTRL, 32'h0);
        src.drive(1'b1, 4);
        axi_write(PACC_ADDR_COUNT, 32'h0);
        axi_write(PACC_ADDR_STAT, 32'h3);
        axi_write(PACC_ADDR_CTRL, 32'h03);
        src.drive(1'b1, 20);
        read_chk(PACC_ADDR_COUNT, 32'h0);
        src.drive(1'b0, 10 * TDIV);
        src.drive(1'b1, 8);
        axi_read(PACC_ADDR_COUNT, r);
        check(32'(rd_data >= 9 && rd_data <= 11), 32'h1);
        read_chk(PACC_ADDR_STAT, 32'h1);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_edge_sel();
        t_ovf_irq();
        t_gated();
        print_verdict();
    end
endmodule // pacc_top_tb

bind pacc_top pacc_assertions #(.TICK_DIV(TICK_DIV)) u_chk (.*);
